// ---- hdl/eio_regs.vh ----
// Notes on behaviour
// R1 - At most four boards, each distinct address
// R2 - Jumper sets upper address digit, four choices
// R3 - Wide board 8..B, other boards C..F
// R4 - Wide board: 24 registers, six groups of four
// R5 - Six port chips, two 8-bit ports each
// R6 - Two 8-bit ports, two 4-bit groups
// R7 - Port access over host data bus
// R8 - Host sets port A output on selector/converter
// R9 - Selector uses A6-A7, converter uses A0-A5
// R10 - Port B wholly free for user logic
// R11 - Port C two groups, isolators, per-group direction
// R12 - Input group samples; output group drives isolator
// R13 - Reset: basic mode, all 24 lines high
// R14 - Outputs latched, inputs pass straight through
// R15 - Mode write clears all output latches
// R16 - Selects only when upper digit matches jumper
`ifndef EIO_REGS_VH
`define EIO_REGS_VH

`define EIO_MAX_BOARDS      3'h4
`define EIO_WIDE_DIGIT_LO   4'h8
`define EIO_WIDE_DIGIT_HI   4'hB
`define EIO_PI_DIGIT_LO     4'hC
`define EIO_PI_DIGIT_HI     4'hF
`define EIO_WIDE_NUM_REGS   5'h18

`define EIO_PI_REG_A        2'h0
`define EIO_PI_REG_B        2'h1
`define EIO_PI_REG_C        2'h2
`define EIO_PI_REG_CTRL     2'h3

`define EIO_CTL_MODE_SET    7
`define EIO_CTL_A_IN        4
`define EIO_CTL_CHI_IN      3
`define EIO_CTL_B_IN        1
`define EIO_CTL_CLO_IN      0

`define EIO_PP_DATA_A       2'h0
`define EIO_PP_DATA_B       2'h1
`define EIO_PP_CTRL_A       2'h2
`define EIO_PP_CTRL_B       2'h3

`define EIO_KIND_DIGITAL    2'h0
`define EIO_KIND_SELECTOR   2'h1
`define EIO_KIND_CONVERTER  2'h2

`define EIO_LATCH_RST       8'hFF
`define EIO_LATCH_CLR       8'h00
`define EIO_DIR_ALL_IN      8'hFF

`endif

// ---- hdl/eio_addr_dec.v ----
`timescale 1ns/100ps
`default_nettype none
`include "eio_regs.vh"

module eio_addr_dec
(
  // Host address
  input  wire [15:0] i_addr,
  // Jumpers
  input  wire [3:0]  i_board_address_jumper,
  input  wire [3:0]  i_wide_board_address_jumper,
  // Selects
  output reg         o_pi_hit,
  output reg  [1:0]  o_pi_reg,
  output reg         o_wide_hit,
  output reg  [4:0]  o_wide_idx
);

  reg pi_jmp_ok;
  reg wide_jmp_ok;

  always @*
  begin
    // R2 jumper digit range
    pi_jmp_ok   = (i_board_address_jumper >= `EIO_PI_DIGIT_LO) &&
                  (i_board_address_jumper <= `EIO_PI_DIGIT_HI);
    // R3 wide board range
    wide_jmp_ok = (i_wide_board_address_jumper >= `EIO_WIDE_DIGIT_LO) &&
                  (i_wide_board_address_jumper <= `EIO_WIDE_DIGIT_HI);
    o_pi_reg    = i_addr[1:0];
    o_wide_idx  = i_addr[4:0];
    o_pi_hit    = 1'b0;
    o_wide_hit  = 1'b0;
    // R16 digit match gates selects
    if (pi_jmp_ok && (i_addr[15:12] == i_board_address_jumper) &&
        (i_addr[11:2] == 10'h000))
    begin
      o_pi_hit = 1'b1;
    end
    else if (wide_jmp_ok && (i_addr[15:12] == i_wide_board_address_jumper) &&
             (i_addr[11:5] == 7'h00) && (i_addr[4:0] < `EIO_WIDE_NUM_REGS))
    begin
      // R4 only 24 registers
      o_wide_hit = 1'b1;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/eio_pp_chip.v ----
`timescale 1ns/100ps
`default_nettype none
`include "eio_regs.vh"

module eio_pp_chip
(
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  // Register access
  input  wire        i_wr,
  input  wire [1:0]  i_reg,
  input  wire [7:0]  i_wdata,
  output reg  [7:0]  o_rdata,
  // Pins, port A in low byte, port B in high byte
  input  wire [15:0] i_pin_in,
  output wire [15:0] o_pin_out,
  output wire [15:0] o_pin_oe_n
);

  // R5 two independent 8-bit ports
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp = gp + 1)
    begin : g_port
      reg [7:0] latch_ff;
      reg [7:0] dir_in_ff;
      always @(posedge i_core_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          latch_ff  <= `EIO_LATCH_RST;
          dir_in_ff <= `EIO_DIR_ALL_IN;
        end
        else if (i_wr && (i_reg == gp))
        begin
          latch_ff <= i_wdata;
        end
        else if (i_wr && (i_reg == gp + 2))
        begin
          dir_in_ff <= i_wdata;
        end
      end
      assign o_pin_out[gp*8 +: 8]  = latch_ff;
      assign o_pin_oe_n[gp*8 +: 8] = dir_in_ff;
    end
  endgenerate

  // Input bits read the pin, output bits read the latch
  always @*
  begin
    case (i_reg)
      `EIO_PP_DATA_A: o_rdata = (i_pin_in[7:0] & g_port[0].dir_in_ff) |
                                (g_port[0].latch_ff & ~g_port[0].dir_in_ff);
      `EIO_PP_DATA_B: o_rdata = (i_pin_in[15:8] & g_port[1].dir_in_ff) |
                                (g_port[1].latch_ff & ~g_port[1].dir_in_ff);
      `EIO_PP_CTRL_A: o_rdata = g_port[0].dir_in_ff;
      default:        o_rdata = g_port[1].dir_in_ff;
    endcase
  end

endmodule
`default_nettype wire

// ---- hdl/eio_top.v ----
`timescale 1ns/100ps
`default_nettype none
`include "eio_regs.vh"

module eio_top
(
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  // Host expansion bus
  input  wire [15:0] i_addr,
  input  wire        i_rd_stb,
  input  wire        i_wr_stb,
  input  wire [7:0]  i_host_data_bus,
  output reg  [7:0]  o_host_data_bus,
  output reg         o_rd_valid,
  // Straps
  input  wire [3:0]  i_board_address_jumper,
  input  wire [3:0]  i_wide_board_address_jumper,
  input  wire [1:0]  i_board_kind,
  // Peripheral interface port A
  input  wire [7:0]  i_pa_in,
  output reg  [7:0]  o_pa_out,
  output reg  [7:0]  o_pa_oe_n,
  // Peripheral interface port B
  input  wire [7:0]  i_pb_in,
  output reg  [7:0]  o_pb_out,
  output reg  [7:0]  o_pb_oe_n,
  // Peripheral interface port C, low group in bits 3:0
  input  wire [7:0]  i_pc_in,
  output reg  [7:0]  o_pc_out,
  output reg  [7:0]  o_pc_oe_n,
  // On-board functions steered by port A
  output reg  [1:0]  o_mux_sel,
  output reg  [5:0]  o_conv_ctl,
  // Wide board pins, chip n port A at 16n, port B at 16n+8
  input  wire [95:0] i_wp_in,
  output wire [95:0] o_wp_out,
  output wire [95:0] o_wp_oe_n
);

  wire       pi_hit;
  wire [1:0] pi_reg;
  wire       wide_hit;
  wire [4:0] wide_idx;

  // R1 one digit per board keeps boards apart
  eio_addr_dec u_dec
  (
    .i_addr                      (i_addr),
    .i_board_address_jumper      (i_board_address_jumper),
    .i_wide_board_address_jumper (i_wide_board_address_jumper),
    .o_pi_hit                    (pi_hit),
    .o_pi_reg                    (pi_reg),
    .o_wide_hit                  (wide_hit),
    .o_wide_idx                  (wide_idx)
  );

  // ---- Peripheral interface state
  reg [7:0] pa_latch_ff;
  reg [7:0] pb_latch_ff;
  reg [7:0] pc_latch_ff;
  reg       a_in_ff;
  reg       b_in_ff;
  reg       clo_in_ff;
  reg       chi_in_ff;
  reg [7:0] nxt_pa_latch;
  reg [7:0] nxt_pb_latch;
  reg [7:0] nxt_pc_latch;
  reg       nxt_a_in;
  reg       nxt_b_in;
  reg       nxt_clo_in;
  reg       nxt_chi_in;
  reg [7:0] pi_rdata;
  reg [7:0] ctrl_rd;
  wire      pi_wr;
  wire      ctl_wr;

  // R7 writes land over the host data bus
  assign pi_wr  = i_wr_stb && pi_hit;
  assign ctl_wr = pi_wr && (pi_reg == `EIO_PI_REG_CTRL);

  always @*
  begin
    nxt_pa_latch = pa_latch_ff;
    nxt_pb_latch = pb_latch_ff;
    nxt_pc_latch = pc_latch_ff;
    nxt_a_in     = a_in_ff;
    nxt_b_in     = b_in_ff;
    nxt_clo_in   = clo_in_ff;
    nxt_chi_in   = chi_in_ff;
    if (ctl_wr && i_host_data_bus[`EIO_CTL_MODE_SET])
    begin
      // R6 direction set per whole port or group
      nxt_a_in   = i_host_data_bus[`EIO_CTL_A_IN];
      nxt_b_in   = i_host_data_bus[`EIO_CTL_B_IN];
      nxt_clo_in = i_host_data_bus[`EIO_CTL_CLO_IN];
      nxt_chi_in = i_host_data_bus[`EIO_CTL_CHI_IN];
      // R15 mode rewrite zeroes output latches
      nxt_pa_latch = `EIO_LATCH_CLR;
      nxt_pb_latch = `EIO_LATCH_CLR;
      nxt_pc_latch = `EIO_LATCH_CLR;
    end
    else if (ctl_wr)
    begin
      // Single bit set or clear on port C
      nxt_pc_latch[i_host_data_bus[3:1]] = i_host_data_bus[0];
    end
    else if (pi_wr)
    begin
      // R14 written values held in latches
      case (pi_reg)
        `EIO_PI_REG_A: nxt_pa_latch = i_host_data_bus;
        `EIO_PI_REG_B: nxt_pb_latch = i_host_data_bus;
        default:       nxt_pc_latch = i_host_data_bus;
      endcase
    end
  end

  // R13 reset: all inputs, latches high
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pa_latch_ff <= `EIO_LATCH_RST;
      pb_latch_ff <= `EIO_LATCH_RST;
      pc_latch_ff <= `EIO_LATCH_RST;
      a_in_ff     <= 1'b1;
      b_in_ff     <= 1'b1;
      clo_in_ff   <= 1'b1;
      chi_in_ff   <= 1'b1;
    end
    else
    begin
      pa_latch_ff <= nxt_pa_latch;
      pb_latch_ff <= nxt_pb_latch;
      pc_latch_ff <= nxt_pc_latch;
      a_in_ff     <= nxt_a_in;
      b_in_ff     <= nxt_b_in;
      clo_in_ff   <= nxt_clo_in;
      chi_in_ff   <= nxt_chi_in;
    end
  end

  // Pins are registered from the next-state values, so they change on the same edge as the state registers
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pa_out  <= `EIO_LATCH_RST;
      o_pa_oe_n <= `EIO_DIR_ALL_IN;
      o_pb_out  <= `EIO_LATCH_RST;
      o_pb_oe_n <= `EIO_DIR_ALL_IN;
      o_pc_out  <= `EIO_LATCH_RST;
      o_pc_oe_n <= `EIO_DIR_ALL_IN;
    end
    else
    begin
      o_pa_out  <= nxt_pa_latch;
      o_pa_oe_n <= {8{nxt_a_in}};
      // R10 port B fully free to the user
      o_pb_out  <= nxt_pb_latch;
      o_pb_oe_n <= {8{nxt_b_in}};
      // R11 port C two independent groups
      // R12 output group drives the isolator source
      o_pc_out  <= nxt_pc_latch;
      o_pc_oe_n <= {{4{nxt_chi_in}}, {4{nxt_clo_in}}};
    end
  end

  // R9 board functions tap port A
  // R8 host keeps port A as output here
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_mux_sel  <= 2'h0;
      o_conv_ctl <= 6'h00;
    end
    else
    begin
      // Held at zero while port A is an input, so a half-set
      // board never steers the mux or converter from the pull-ups
      if ((i_board_kind == `EIO_KIND_SELECTOR) && !nxt_a_in)
      begin
        o_mux_sel <= nxt_pa_latch[7:6];
      end
      else
      begin
        o_mux_sel <= 2'h0;
      end
      if ((i_board_kind == `EIO_KIND_CONVERTER) && !nxt_a_in)
      begin
        o_conv_ctl <= nxt_pa_latch[5:0];
      end
      else
      begin
        o_conv_ctl <= 6'h00;
      end
    end
  end

  // R14 inputs read straight from pins
  always @*
  begin
    ctrl_rd = 8'h00;
    ctrl_rd[`EIO_CTL_MODE_SET] = 1'b1;
    ctrl_rd[`EIO_CTL_A_IN]     = a_in_ff;
    ctrl_rd[`EIO_CTL_B_IN]     = b_in_ff;
    ctrl_rd[`EIO_CTL_CLO_IN]   = clo_in_ff;
    ctrl_rd[`EIO_CTL_CHI_IN]   = chi_in_ff;
    case (pi_reg)
      `EIO_PI_REG_A: pi_rdata = a_in_ff ? i_pa_in : pa_latch_ff;
      `EIO_PI_REG_B: pi_rdata = b_in_ff ? i_pb_in : pb_latch_ff;
      `EIO_PI_REG_C:
      begin
        // R12 input group samples isolator output
        pi_rdata[3:0] = clo_in_ff ? i_pc_in[3:0] : pc_latch_ff[3:0];
        pi_rdata[7:4] = chi_in_ff ? i_pc_in[7:4] : pc_latch_ff[7:4];
      end
      default:       pi_rdata = ctrl_rd;
    endcase
  end

  // ---- Wide board: six port chips
  wire [47:0] wide_rd_bus;
  wire [2:0]  wide_chip;
  wire [1:0]  wide_reg;
  reg  [7:0]  wide_rdata;

  // R4 six groups of four registers
  assign wide_chip = wide_idx[4:2];
  assign wide_reg  = wide_idx[1:0];

  genvar gc;
  generate
    for (gc = 0; gc < 6; gc = gc + 1)
    begin : g_chip
      // R5 each chip two 8-bit ports
      eio_pp_chip u_chip
      (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_wr       (i_wr_stb && wide_hit && (wide_chip == gc)),
        .i_reg      (wide_reg),
        .i_wdata    (i_host_data_bus),
        .o_rdata    (wide_rd_bus[gc*8 +: 8]),
        .i_pin_in   (i_wp_in[gc*16 +: 16]),
        .o_pin_out  (o_wp_out[gc*16 +: 16]),
        .o_pin_oe_n (o_wp_oe_n[gc*16 +: 16])
      );
    end
  endgenerate

  always @*
  begin
    case (wide_chip)
      3'h0:    wide_rdata = wide_rd_bus[7:0];
      3'h1:    wide_rdata = wide_rd_bus[15:8];
      3'h2:    wide_rdata = wide_rd_bus[23:16];
      3'h3:    wide_rdata = wide_rd_bus[31:24];
      3'h4:    wide_rdata = wide_rd_bus[39:32];
      default: wide_rdata = wide_rd_bus[47:40];
    endcase
  end

  // ---- Read return, one cycle after the strobe
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_host_data_bus <= 8'h00;
      o_rd_valid      <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_stb && (pi_hit || wide_hit);
      // R7 reads return over host data bus
      if (i_rd_stb && pi_hit)
      begin
        o_host_data_bus <= pi_rdata;
      end
      else if (i_rd_stb && wide_hit)
      begin
        o_host_data_bus <= wide_rdata;
      end
      else if (i_rd_stb)
      begin
        o_host_data_bus <= 8'h00;
      end
    end
  end

endmodule
`default_nettype wire

// ---- sim/eio_field.sv ----
`timescale 1ns/100ps
`default_nettype none
module eio_field #(
  parameter int W = 8
) (
  // Pins of the block
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe_n,
  // Level forced by field wiring
  input  wire logic [W-1:0] i_ext,
  output logic      [W-1:0] o_in
);
  // shared line level
  // Driven bits read back own value, released bits see the external source
  assign o_in = (i_out & ~i_oe_n) | (i_ext & i_oe_n);
endmodule
`default_nettype wire

// ---- sim/eio_top_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module eio_chk (
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  // Host bus
  input wire logic [15:0] i_addr,
  input wire logic        i_rd_stb,
  input wire logic        i_wr_stb,
  input wire logic [7:0]  i_host_data_bus,
  input wire logic [7:0]  o_host_data_bus,
  input wire logic        o_rd_valid,
  // Straps
  input wire logic [3:0]  i_board_address_jumper,
  input wire logic [3:0]  i_wide_board_address_jumper,
  input wire logic [1:0]  i_board_kind,
  // Pins
  input wire logic [7:0]  o_pa_out,
  input wire logic [7:0]  o_pa_oe_n,
  input wire logic [7:0]  o_pb_out,
  input wire logic [7:0]  o_pc_out,
  input wire logic [7:0]  o_pc_oe_n,
  input wire logic [1:0]  o_mux_sel,
  input wire logic [5:0]  o_conv_ctl,
  input wire logic [95:0] o_wp_out
);
  logic pi_hit;
  logic pi_wr;
  logic mode_wr;
  assign pi_hit = i_board_address_jumper >= 4'hC && i_addr[15:12] == i_board_address_jumper
                  && i_addr[11:2] == 10'h000;
  assign pi_wr = i_wr_stb && pi_hit;
  assign mode_wr = pi_wr && i_addr[1:0] == 2'h3 && i_host_data_bus[7];
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  chk_rd_answer: assert property (i_rd_stb && pi_hit |=> o_rd_valid)
    else $error("read hit not answered");
  chk_rd_cause: assert property (o_rd_valid |-> $past(i_rd_stb))
    else $error("read valid without strobe");
  chk_latch_a: assert property (pi_wr && i_addr[1:0] == 2'h0 && o_pa_oe_n == 8'h00
    |=> o_pa_out == $past(i_host_data_bus)) else $error("port A latch wrong");
  chk_mode_clear: assert property (mode_wr
    |=> {o_pa_out, o_pb_out, o_pc_out} == 24'h00_0000)
    else $error("mode write left outputs set");
  chk_mode_dir: assert property (mode_wr |=> o_pa_oe_n == {8{$past(i_host_data_bus[4])}})
    else $error("port A direction wrong");
  chk_c_groups: assert property ((o_pc_oe_n[3:0] == 4'h0 || o_pc_oe_n[3:0] == 4'hF)
    && (o_pc_oe_n[7:4] == 4'h0 || o_pc_oe_n[7:4] == 4'hF)) else $error("port C group split");
  chk_mux_sel: assert property (o_mux_sel == (($past(i_board_kind) == 2'h1
    && o_pa_oe_n == 8'h00) ? o_pa_out[7:6] : 2'h0)) else $error("mux select wrong");
  chk_conv_ctl: assert property (o_conv_ctl == (($past(i_board_kind) == 2'h2
    && o_pa_oe_n == 8'h00) ? o_pa_out[5:0] : 6'h00)) else $error("converter control wrong");
  chk_wide_quiet: assert property (!$past(i_wr_stb) |-> $stable(o_wp_out))
    else $error("wide pins moved without write");
  chk_rd_hold: assert property (!$past(i_rd_stb) |-> $stable(o_host_data_bus))
    else $error("read data moved without read");
  cov_read: cover property (i_rd_stb && pi_hit ##1 o_rd_valid);
  cov_mode: cover property (mode_wr);
  cov_mux: cover property (o_mux_sel == 2'h3);
endmodule
bind eio_top eio_chk u_chk (.i_core_clk, .i_rst_n, .i_addr, .i_rd_stb, .i_wr_stb,
  .i_host_data_bus, .o_host_data_bus, .o_rd_valid, .i_board_address_jumper,
  .i_wide_board_address_jumper, .i_board_kind, .o_pa_out, .o_pa_oe_n, .o_pb_out,
  .o_pc_out, .o_pc_oe_n, .o_mux_sel, .o_conv_ctl, .o_wp_out);
`default_nettype wire

// ---- sim/eio_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module eio_top_tb;
  logic        i_core_clk, i_rst_n, i_rd_stb, i_wr_stb, o_rd_valid;
  logic [15:0] i_addr;
  logic [7:0]  i_host_data_bus, o_host_data_bus, i_pa_in, o_pa_out, o_pa_oe_n, i_pb_in;
  logic [7:0]  o_pb_out, o_pb_oe_n, i_pc_in, o_pc_out, o_pc_oe_n, xa, xb, xc, v;
  logic [3:0]  i_board_address_jumper, i_wide_board_address_jumper;
  logic [1:0]  i_board_kind, o_mux_sel;
  logic [5:0]  o_conv_ctl;
  logic [95:0] i_wp_in, o_wp_out, o_wp_oe_n, xw, snap;
  int          n_mismatch, checks_done, seed, k;

  eio_top u_dut (.i_core_clk, .i_rst_n, .i_addr, .i_rd_stb, .i_wr_stb, .i_host_data_bus,
    .o_host_data_bus, .o_rd_valid, .i_board_address_jumper, .i_wide_board_address_jumper,
    .i_board_kind, .i_pa_in, .o_pa_out, .o_pa_oe_n, .i_pb_in, .o_pb_out, .o_pb_oe_n,
    .i_pc_in, .o_pc_out, .o_pc_oe_n, .o_mux_sel, .o_conv_ctl, .i_wp_in, .o_wp_out, .o_wp_oe_n);
  eio_field #(.W(8)) u_fa (.i_out(o_pa_out), .i_oe_n(o_pa_oe_n), .i_ext(xa), .o_in(i_pa_in));
  eio_field #(.W(8)) u_fb (.i_out(o_pb_out), .i_oe_n(o_pb_oe_n), .i_ext(xb), .o_in(i_pb_in));
  eio_field #(.W(8)) u_fc (.i_out(o_pc_out), .i_oe_n(o_pc_oe_n), .i_ext(xc), .o_in(i_pc_in));
  eio_field #(.W(96)) u_fw (.i_out(o_wp_out), .i_oe_n(o_wp_oe_n), .i_ext(xw), .o_in(i_wp_in));

  initial
  begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  function automatic logic [15:0] pa(input logic [1:0] r);
    return {i_board_address_jumper, 10'h000, r};
  endfunction

  function automatic logic [15:0] wa(input int c, input logic [1:0] r);
    return {i_wide_board_address_jumper, 7'h00, c[2:0], r};
  endfunction

  function automatic logic [7:0] ctl_rd(input logic [7:0] m);
    return {1'b1, 2'b00, m[4], m[3], 1'b0, m[1], m[0]};
  endfunction

  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Every output at its reset level
  task automatic chk_reset();
    chk({o_pa_out, o_pa_oe_n, o_pb_out, o_pb_oe_n}, 32'hFFFF_FFFF);
    chk({o_pc_out, o_pc_oe_n, o_mux_sel, o_conv_ctl}, 24'hFF_FF00);
    chk(o_wp_out, {96{1'b1}});
    chk(o_wp_oe_n, {96{1'b1}});
    chk({o_rd_valid, o_host_data_bus}, 9'h000);
  endtask

  // Strobe held one cycle, released after the taking edge
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1 i_addr = a;
    i_host_data_bus = d;
    i_wr_stb = 1'b1;
    @(posedge i_core_clk);
    #1 i_wr_stb = 1'b0;
  endtask

  task automatic rd8(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    #1 i_addr = a;
    i_rd_stb = 1'b1;
    @(posedge i_core_clk);
    #1 i_rd_stb = 1'b0;
    d = o_host_data_bus;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd8(a, d);
    chk({o_rd_valid, d}, {1'b1, e});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    seed = 95509;
    k = $random(seed);
    {i_rd_stb, i_wr_stb, i_addr, i_host_data_bus, i_board_kind} = '0;
    i_board_address_jumper = {2'b11, k[1:0]};
    i_wide_board_address_jumper = {2'b10, k[3:2]};
    {xa, xb, xc} = 24'h00_0000;
    xw = {$random(seed), $random(seed), $random(seed)};
    i_rst_n = 1'b0;
    repeat (8) @(posedge i_core_clk);
    #1 i_rst_n = 1'b1;
    chk_reset();
    $display("test reset done");
    wr8(pa(3), 8'h80);
    wr8(pa(0), 8'h55);
    chk({o_pa_out, o_pa_oe_n}, 16'h5500);
    wr8(pa(1), 8'hA6);
    wr8(pa(2), 8'h9C);
    rdchk(pa(0), 8'h55);
    rdchk(pa(1), 8'hA6);
    wr8(pa(3), 8'h80);
    chk({o_pa_out, o_pb_out, o_pc_out}, 24'h00_0000);
    $display("test latch done");
    wr8(pa(3), 8'h91);
    chk({o_pa_oe_n, o_pc_oe_n}, 16'hFF0F);
    wr8(pa(2), 8'hA5);
    chk(o_pc_out[7:4], 4'hA);
    xa = 8'h3C;
    xc = 8'h96;
    rdchk(pa(0), 8'h3C);
    rdchk(pa(2), 8'hA6);
    wr8(pa(3), 8'h0A);
    chk(o_pc_out, 8'h85);
    rdchk(pa(2), 8'h86);
    wr8(pa(3), 8'h0D);
    chk(o_pc_out, 8'hC5);
    xa = 8'hC3;
    rdchk(pa(0), 8'hC3);
    rdchk(pa(3), ctl_rd(8'h91));
    for (k = 0; k < 16; k++)
    begin
      v = 8'($random(seed));
      wr8(pa(1), v);
      chk(o_pb_out, v);
      rdchk(pa(1), v);
    end
    $display("test input done");
    for (k = 0; k < 4; k++)
    begin
      i_board_kind = k[1:0];
      // host sets port A output first
      wr8(pa(3), 8'h80);
      wr8(pa(0), 8'hD7);
      chk({o_mux_sel, o_conv_ctl}, {k == 1 ? 2'h3 : 2'h0, k == 2 ? 6'h17 : 6'h00});
    end
    i_board_kind = 2'h0;
    wr8(pa(0) ^ 16'h1000, 8'h11);
    wr8(pa(0) | 16'h0100, 8'h22);
    chk(o_pa_out, 8'hD7);
    rd8(pa(0) ^ 16'h1000, v);
    chk(o_rd_valid, 1'b0);
    // Jumper outside its digit range: board never selected
    i_board_address_jumper ^= 4'h8;
    wr8(pa(0), 8'h33);
    chk(o_pa_out, 8'hD7);
    i_board_address_jumper ^= 4'h8;
    $display("test decode done");
    for (k = 0; k < 6; k++)
    begin
      v = 8'($random(seed));
      wr8(wa(k, 2), 8'h00);
      wr8(wa(k, 0), v);
      chk({o_wp_out[16*k +: 8], o_wp_oe_n[16*k +: 8]}, {v, 8'h00});
      wr8(wa(k, 3), 8'h0F);
      wr8(wa(k, 1), 8'h33);
      rdchk(wa(k, 1), {4'h3, xw[16*k+8 +: 4]});
      rdchk(wa(k, 3), 8'h0F);
    end
    snap = o_wp_out;
    wr8(wa(6, 0), 8'h00);
    chk(o_wp_out, snap);
    $display("test wide done");
    i_rst_n = 1'b0;
    @(posedge i_core_clk);
    #1 i_rst_n = 1'b1;
    chk_reset();
    rdchk(pa(3), ctl_rd(8'hFF));
    $display("test reset again done");
    conclude();
  end
endmodule
`default_nettype wire
